// File: rfhc_cmd_front.sv
// Command front end: frame checks, end codes, link commands, response replay
`timescale 1ns/1ps
// Notes on behaviour
// - Parity fault answers 10, CR framing only
// - Framing fault answers 11
// - Overrun fault answers 12
// - Bad block check answers 13, counted framing
// - Malformed or undefined command answers 14
// - Gap over two seconds answers 18, CR framing only
// - CR frame over 140 characters answers 18
// - Counted frame over 73 bytes answers 18
// - Disturbed tag exchange answers 70
// - Protected, read-only or worn page answers 71
// - No tag answers 72, also missing pages when alt_chip is set
// - Missing pages answer 7A when alt_chip is clear
// - ISO errors 01,02,03,0F,reserved map to 79
// - ISO error 10 maps to 7A
// - ISO error 11 reports 00
// - ISO errors 12,13,14 map to 71
// - Test command echoes data after 00
// - Acknowledge gets no reply
// - Negative acknowledge resends previous response unchanged
// - Stop aborts, halts oscillation, sleeps, answers 00
// - Continuous mode waits acknowledge before next read
// - Stop ends a command waiting for tag
module rfhc_cmd_front #(
   parameter int GAP_CYCLES = rfhc_pkg::GAP_CYC
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Mode selection
   input wire logic carriage_return_framing,
   input wire logic [3:0] comm_mode,
   // Serial receive and transmit
   input rfhc_pkg::rfhc_rx_t rx_in,
   output logic tx_valid,
   output logic [7:0] tx_char,
   input wire logic tx_ready,
   // Tag engine
   output logic tag_start,
   output logic [15:0] tag_cmd,
   output logic tag_next,
   output logic tag_abort,
   output logic osc_en,
   output logic sleep,
   input rfhc_pkg::rfhc_tag_t tag_res
);
   import rfhc_pkg::*;

   localparam int GW = $clog2(GAP_CYCLES + 1);

   rfhc_state_t st_q, ret_q;
   logic [7:0] cnt_q, c0_q, c1_q, fe_len_q, rsp_len_q, new_len_q, rd_idx_q, rd_data;
   logic [GW-1:0] gap_q;
   logic par_q, frm_q, ovr_q, over_q;
   logic fe_q, fe_par_q, fe_frm_q, fe_ovr_q, fe_bcc_q, fe_over_q, fe_gap_q;
   logic bank_q, wr_step_q, fetch_q, cr_done_q;
   logic [15:0] wr_code_q;

   logic acc, is_cr, store, end_ev, gap_hit, limit_hit, rd_go, send_done, mem_we;
   logic fe_take, bad, fmt_err, is_gen, ev_test, ev_ack, ev_nack, ev_stop;
   logic stop_take, start_take, done_take, lk_err;
   logic [7:0] limit, mem_wdata;
   logic [15:0] lk_code;
   logic [8:0] mem_waddr;

   // Receive side: chars are dropped only for the two cycles of a code write
   assign acc = rx_in.valid && st_q != S_WR;
   assign is_cr = carriage_return_framing && rx_in.chr == CH_CR;
   assign store = acc && !is_cr;
   assign limit = carriage_return_framing ? MAX_CR_CHARS : MAX_LEN_BYTES;
   assign limit_hit = store && cnt_q == limit;
   assign gap_hit = carriage_return_framing && cnt_q != 8'h00 && !rx_in.valid
                    && gap_q == GW'(GAP_CYCLES);
   assign end_ev = (acc && (is_cr || (!carriage_return_framing && rx_in.last)))
                   || gap_hit;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         {cnt_q, c0_q, c1_q} <= 24'h000000;
         gap_q <= '0;
      end
      else
      begin
         gap_q <= acc ? '0 : (gap_q == GW'(GAP_CYCLES) ? gap_q : gap_q + 1'b1);
         if (store && cnt_q == 8'h00)
            c0_q <= rx_in.chr;
         if (store && cnt_q == 8'h01)
            c1_q <= rx_in.chr;
         if (end_ev)
            cnt_q <= 8'h00;
         else if (store && !limit_hit)
            cnt_q <= cnt_q + 8'h01;
      end
   end

   // Faults gather over the frame and are handed over at its end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         {par_q, frm_q, ovr_q, over_q} <= 4'h0;
         {fe_q, fe_par_q, fe_frm_q, fe_ovr_q, fe_bcc_q, fe_over_q, fe_gap_q} <= 7'h00;
         fe_len_q <= 8'h00;
      end
      else
      begin
         if (end_ev)
         begin
            fe_par_q <= par_q || (acc && rx_in.par_err && carriage_return_framing);
            fe_frm_q <= frm_q || (acc && rx_in.frm_err);
            fe_ovr_q <= ovr_q || (acc && rx_in.ovr_err);
            fe_bcc_q <= acc && !carriage_return_framing && rx_in.bcc_bad;
            fe_over_q <= over_q || limit_hit;
            fe_gap_q <= gap_hit;
            fe_len_q <= (store && !limit_hit) ? cnt_q + 8'h01 : cnt_q;
            {par_q, frm_q, ovr_q, over_q} <= 4'h0;
         end
         else if (acc)
         begin
            par_q <= par_q || (rx_in.par_err && carriage_return_framing);
            frm_q <= frm_q || rx_in.frm_err;
            ovr_q <= ovr_q || rx_in.ovr_err;
            over_q <= over_q || limit_hit;
         end
         // A frame ending while one is pending replaces it
         fe_q <= end_ev || (fe_q && !fe_take);
      end
   end

   // Frame decode
   assign fe_take = fe_q && (st_q == S_IDLE || st_q == S_WAIT || st_q == S_ACK);
   assign is_gen = fe_len_q >= 8'h02 && c0_q == CH_GEN;
   assign ev_test = is_gen && c1_q == CH_TEST;
   assign ev_ack = is_gen && c1_q == CH_ACK && fe_len_q == 8'h02;
   assign ev_nack = is_gen && c1_q == CH_NACK && fe_len_q == 8'h02;
   assign ev_stop = is_gen && c1_q == CH_STOP && fe_len_q == 8'h02;
   assign fmt_err = fe_len_q < 8'h02 || (is_gen && !ev_test && !ev_ack
                    && !ev_nack && !ev_stop);
   assign bad = lk_err || fmt_err;
   assign stop_take = fe_take && !bad && ev_stop;
   assign start_take = fe_take && !bad && !is_gen && st_q == S_IDLE;
   assign done_take = st_q == S_WAIT && !fe_take && tag_res.done;

   // Link faults outrank format and tag faults
   always_comb
   begin
      lk_err = 1'b1;
      if (fe_par_q)
         lk_code = EC_PARITY;
      else if (fe_frm_q)
         lk_code = EC_FRAMING;
      else if (fe_ovr_q)
         lk_code = EC_OVERRUN;
      else if (fe_bcc_q)
         lk_code = EC_BCC;
      else if (fe_over_q || fe_gap_q)
         lk_code = EC_FRAME;
      else
      begin
         lk_code = EC_FORMAT;
         lk_err = 1'b0;
      end
   end

   // Main sequencer
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st_q <= S_IDLE;
         ret_q <= S_IDLE;
         wr_code_q <= EC_OK;
         {new_len_q, rsp_len_q} <= 16'h0000;
         {wr_step_q, bank_q, tag_start, tag_next, tag_abort} <= 5'h00;
         tag_cmd <= 16'h0000;
      end
      else
      begin
         tag_start <= start_take;
         tag_next <= 1'b0;
         tag_abort <= stop_take;
         case (st_q)
            S_IDLE, S_WAIT, S_ACK:
            begin
               if (fe_take && bad)
               begin
                  st_q <= S_WR;
                  ret_q <= st_q;
                  wr_code_q <= lk_code;
                  new_len_q <= 8'h02;
               end
               else if (stop_take)
               begin
                  st_q <= S_WR;
                  ret_q <= S_IDLE;
                  wr_code_q <= EC_OK;
                  new_len_q <= 8'h02;
               end
               else if (fe_take && ev_test)
               begin
                  st_q <= S_WR;
                  ret_q <= st_q;
                  wr_code_q <= EC_OK;
                  new_len_q <= fe_len_q;
               end
               else if (fe_take && ev_nack)
               begin
                  st_q <= S_SEND;
                  ret_q <= st_q;
               end
               else if (fe_take && ev_ack && st_q == S_ACK)
               begin
                  tag_next <= 1'b1;
                  st_q <= S_WAIT;
               end
               else if (start_take)
               begin
                  tag_cmd <= {c0_q, c1_q};
                  st_q <= S_WAIT;
               end
               else if (done_take)
               begin
                  st_q <= S_WR;
                  ret_q <= (comm_mode == MODE_CONT) ? S_ACK : S_IDLE;
                  wr_code_q <= rfhc_tag_code(tag_res);
                  new_len_q <= 8'h02;
               end
            end
            S_WR:
            begin
               wr_step_q <= !wr_step_q;
               if (wr_step_q)
               begin
                  bank_q <= !bank_q;
                  rsp_len_q <= new_len_q;
                  st_q <= S_SEND;
               end
            end
            S_SEND:
            begin
               if (send_done)
                  st_q <= ret_q;
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   // Radio state follows tag commands and stop
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         {osc_en, sleep} <= {RST_OSC, RST_SLEEP};
      else if (stop_take)
         {osc_en, sleep} <= 2'b01;
      else if (start_take)
         {osc_en, sleep} <= 2'b10;
      else if (done_take && comm_mode != MODE_CONT)
      begin
         osc_en <= comm_mode[3];
         sleep <= 1'b1;
      end
   end

   // Transmit: one char every third cycle at best, trading speed for no skid
   assign rd_go = st_q == S_SEND && !fetch_q && !tx_valid && rd_idx_q != rsp_len_q;
   assign send_done = st_q == S_SEND && !fetch_q && !tx_valid
                      && rd_idx_q == rsp_len_q && (cr_done_q || !carriage_return_framing);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         {tx_valid, fetch_q, cr_done_q} <= 3'h0;
         {tx_char, rd_idx_q} <= 16'h0000;
      end
      else
      begin
         fetch_q <= rd_go;
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
         if (st_q != S_SEND)
         begin
            rd_idx_q <= 8'h00;
            cr_done_q <= 1'b0;
         end
         else if (rd_go)
            rd_idx_q <= rd_idx_q + 8'h01;
         else if (!fetch_q && !tx_valid && carriage_return_framing && !cr_done_q)
         begin
            tx_valid <= 1'b1;
            tx_char <= CH_CR;
            cr_done_q <= 1'b1;
         end
         if (fetch_q)
         begin
            tx_valid <= 1'b1;
            tx_char <= rd_data;
         end
      end
   end

   // New frames fill the idle bank; the live bank is only replaced on commit
   assign mem_we = st_q == S_WR || store;
   assign mem_waddr = st_q == S_WR ? {!bank_q, 7'h00, wr_step_q} : {!bank_q, cnt_q};
   assign mem_wdata = st_q == S_WR ? (wr_step_q ? wr_code_q[7:0] : wr_code_q[15:8])
                      : rx_in.chr;

   rfhc_rsp_mem #(
      .DW(8),
      .AW(9)
   ) u_mem (
      .clk(ref_clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .re(rd_go),
      .raddr({bank_q, rd_idx_q}),
      .rdata_q(rd_data)
   );

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence sq_code_emit;
      mem_we && mem_wdata == wr_code_q[15:8] ##1 mem_wdata == wr_code_q[7:0]
      ##1 st_q == S_SEND;
   endsequence

   a_code_emit: assert property (st_q == S_WR && !wr_step_q |-> sq_code_emit)
      else $error("end code not written in two steps");
   a_stop_reply: assert property (stop_take |=> tag_abort && sleep && !osc_en
      && wr_code_q == EC_OK && st_q == S_WR)
      else $error("stop did not abort and answer 00");
   a_ack_silent: assert property (fe_take && !bad && ev_ack && st_q != S_ACK
      |=> st_q == $past(st_q) && !tag_next)
      else $error("acknowledge produced activity");
   a_ack_next: assert property (fe_take && !bad && ev_ack && st_q == S_ACK
      |=> tag_next && st_q == S_WAIT)
      else $error("acknowledge did not release next read");
   a_nack_replay: assert property (fe_take && !bad && ev_nack
      |=> st_q == S_SEND && $stable(bank_q) && $stable(rsp_len_q))
      else $error("resend changed the response");
   a_parity_first: assert property (fe_take && fe_par_q |=> wr_code_q == EC_PARITY)
      else $error("parity fault not reported first");
   a_gap_cut: assert property (gap_hit |=> fe_q && fe_gap_q)
      else $error("gap timeout did not close frame");
   a_over_code: assert property (fe_take && fe_over_q && !fe_par_q && !fe_frm_q
      && !fe_ovr_q && !fe_bcc_q |=> wr_code_q == EC_FRAME)
      else $error("long frame not answered 18");
   a_iso_relock: assert property (done_take && tag_res.kind == TK_ISO
      && tag_res.iso_code == ISO_RELOCK |=> wr_code_q == EC_OK)
      else $error("relock not reported as normal end");
   a_echo_len: assert property (fe_take && !bad && ev_test
      |=> new_len_q == $past(fe_len_q) ##2 rsp_len_q == $past(fe_len_q, 3))
      else $error("echo length wrong");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("transmit char dropped under back-pressure");
endmodule

// File: rfhc_host_model.sv
// Host control unit model: sends command characters, collects response characters
`timescale 1ns/1ps
module rfhc_host_model (
   // Clock
   input wire logic ref_clk,
   // Command characters toward the device
   output rfhc_pkg::rfhc_rx_t rx_in,
   // Response characters from the device
   input wire logic tx_valid,
   input wire logic [7:0] tx_char,
   output logic tx_ready,
   // Pace of the host receiver
   input wire logic slow
);
   import rfhc_pkg::*;
   logic [7:0] got_q[$];
   logic [1:0] pace;
   initial
   begin
      rx_in = '0;
      tx_ready = 1'b1;
      pace = 2'h0;
   end
   // A stalling host is ready one cycle in four
   always @(negedge ref_clk)
   begin
      pace <= pace + 2'h1;
      tx_ready <= !slow || (pace == 2'h3);
   end
   always @(posedge ref_clk)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got_q.push_back(tx_char);
   end
   // Between chars the data lines show the inverse, never a stale copy
   task automatic send(input logic [7:0] c, input logic [4:0] fl);
      @(negedge ref_clk);
      rx_in <= {1'b1, c, fl};
      @(negedge ref_clk);
      rx_in <= {1'b0, ~c, 5'h0};
   endtask
endmodule

// File: rfhc_pkg.sv
// Shared constants, types and end-code mapping for the reader host command front end
package rfhc_pkg;
   // Two-character end codes, ASCII, first character in the upper byte
   localparam logic [15:0] EC_OK = 16'h3030;
   localparam logic [15:0] EC_PARITY = 16'h3130;
   localparam logic [15:0] EC_FRAMING = 16'h3131;
   localparam logic [15:0] EC_OVERRUN = 16'h3132;
   localparam logic [15:0] EC_BCC = 16'h3133;
   localparam logic [15:0] EC_FORMAT = 16'h3134;
   localparam logic [15:0] EC_FRAME = 16'h3138;
   localparam logic [15:0] EC_COMM = 16'h3730;
   localparam logic [15:0] EC_WRITE = 16'h3731;
   localparam logic [15:0] EC_NOTAG = 16'h3732;
   localparam logic [15:0] EC_CMD = 16'h3739;
   localparam logic [15:0] EC_ADDR = 16'h3741;

   // Command characters
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_GEN = 8'h31;
   localparam logic [7:0] CH_TEST = 8'h30;
   localparam logic [7:0] CH_ACK = 8'h31;
   localparam logic [7:0] CH_NACK = 8'h32;
   localparam logic [7:0] CH_STOP = 8'h33;
   localparam logic [3:0] MODE_CONT = 4'ha;

   // Error codes returned by ISO tags
   localparam logic [7:0] ISO_NOBLK = 8'h10;
   localparam logic [7:0] ISO_RELOCK = 8'h11;
   localparam logic [7:0] ISO_LOCKED = 8'h12;
   localparam logic [7:0] ISO_WRFAIL = 8'h13;
   localparam logic [7:0] ISO_LKFAIL = 8'h14;

   // Frame limits and timing
   localparam logic [7:0] MAX_CR_CHARS = 8'h8c;
   localparam logic [7:0] MAX_LEN_BYTES = 8'h49;
   localparam int CLK_HZ = 40_000_000;
   localparam int GAP_MS = 2000;
   localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);

   // Reset values
   localparam logic RST_SLEEP = 1'b1;
   localparam logic RST_OSC = 1'b0;

   typedef enum logic [2:0]
   {
      TK_OK = 3'h0,
      TK_COMM = 3'h1,
      TK_WRITE = 3'h2,
      TK_NOTAG = 3'h3,
      TK_NOPAGE = 3'h4,
      TK_ISO = 3'h5,
      TK_FMT = 3'h6
   } rfhc_tkind_t;

   typedef enum logic [4:0]
   {
      S_IDLE = 5'b00001,
      S_WAIT = 5'b00010,
      S_ACK = 5'b00100,
      S_WR = 5'b01000,
      S_SEND = 5'b10000
   } rfhc_state_t;

   // One received character with its line status
   typedef struct packed
   {
      logic valid;
      logic [7:0] chr;
      logic par_err;
      logic frm_err;
      logic ovr_err;
      logic last;
      logic bcc_bad;
   } rfhc_rx_t;

   // Completion report from the tag engine
   typedef struct packed
   {
      logic done;
      rfhc_tkind_t kind;
      logic alt_chip;
      logic [7:0] iso_code;
   } rfhc_tag_t;

   function automatic logic [15:0] rfhc_tag_code(input rfhc_tag_t t);
      case (t.kind)
         TK_OK: return EC_OK;
         TK_COMM: return EC_COMM;
         TK_WRITE: return EC_WRITE;
         TK_NOTAG: return EC_NOTAG;
         TK_NOPAGE: return t.alt_chip ? EC_NOTAG : EC_ADDR;
         TK_FMT: return EC_FORMAT;
         TK_ISO:
         begin
            case (t.iso_code)
               ISO_NOBLK: return EC_ADDR;
               ISO_RELOCK: return EC_OK;
               ISO_LOCKED, ISO_WRFAIL, ISO_LKFAIL: return EC_WRITE;
               default: return EC_CMD;
            endcase
         end
         default: return EC_COMM;
      endcase
   endfunction
endpackage

// File: rfhc_rsp_mem.sv
// Two-bank response store, registered read data
`timescale 1ns/1ps
module rfhc_rsp_mem #(
   parameter int DW = 8,
   parameter int AW = 9
)(
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (re)
      begin
         rdata_q <= mem_q[raddr];
      end
   end
endmodule

// File: rfid_reader_host_command_status_bench.sv
// Self-checking bench for the reader host command front end
`timescale 1ns/1ps
module rfid_reader_host_command_status_bench;
   import rfhc_pkg::*;
   localparam int GAP = 50;
   logic ref_clk;
   logic srst;
   logic carriage_return_framing;
   logic [3:0] comm_mode;
   rfhc_rx_t rx_in;
   logic tx_valid;
   logic [7:0] tx_char;
   logic tx_ready;
   logic tag_start;
   logic [15:0] tag_cmd;
   logic tag_next;
   logic tag_abort;
   logic osc_en;
   logic sleep;
   rfhc_tag_t tag_res;
   logic slow;
   int err_count;
   int n_checks;
   int n_start;
   int n_next;
   int n_abort;

   rfhc_cmd_front #(.GAP_CYCLES(GAP)) DUT (.ref_clk(ref_clk), .srst(srst),
      .carriage_return_framing(carriage_return_framing), .comm_mode(comm_mode),
      .rx_in(rx_in), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
      .tag_start(tag_start), .tag_cmd(tag_cmd), .tag_next(tag_next),
      .tag_abort(tag_abort), .osc_en(osc_en), .sleep(sleep), .tag_res(tag_res));
   rfhc_host_model host (.ref_clk(ref_clk), .rx_in(rx_in), .tx_valid(tx_valid),
      .tx_char(tx_char), .tx_ready(tx_ready), .slow(slow));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Pulse counters, so no one-cycle pulse slips past a task
   always @(posedge ref_clk)
   begin
      if (tag_start === 1'b1)
         n_start <= n_start + 1;
      if (tag_next === 1'b1)
         n_next <= n_next + 1;
      if (tag_abort === 1'b1)
         n_abort <= n_abort + 1;
   end

   task automatic conclude;
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Carriage return shows as a tilde so a message stays on one line
   task automatic chk_rsp(input string exp);
      string seen;
      logic [7:0] c;
      int t;
      seen = "";
      t = 0;
      while (host.got_q.size() < exp.len() && t < 3000)
      begin
         @(negedge ref_clk);
         t++;
      end
      repeat (16) @(negedge ref_clk);
      while (host.got_q.size() > 0)
      begin
         c = host.got_q.pop_front();
         seen = $sformatf("%s%c", seen, (c === CH_CR) ? 8'h7e : c);
      end
      n_checks++;
      if (seen != exp)
      begin
         err_count++;
         $display("wrong value response expected %s seen %s", exp, seen);
      end
   endtask

   task automatic frame(input string s, input int epos, input logic [2:0] ef, input logic bcc);
      logic lst;
      for (int i = 0; i < s.len(); i++)
      begin
         lst = (i == s.len() - 1);
         host.send(s[i], {(i == epos) ? ef : 3'h0, !carriage_return_framing && lst, bcc && lst});
      end
      if (carriage_return_framing)
         host.send(CH_CR, 5'h0);
   endtask

   task automatic t_link;
      string s;
      frame("10AB", -1, 3'h0, 1'b0);
      chk_rsp("00AB~");
      slow = 1'b1;
      frame("12", -1, 3'h0, 1'b0);
      chk_rsp("00AB~");
      slow = 1'b0;
      frame("10AB", 2, 3'h4, 1'b0);
      chk_rsp("10~");
      frame("10AB", 3, 3'h2, 1'b0);
      chk_rsp("11~");
      frame("10AB", 0, 3'h1, 1'b0);
      chk_rsp("12~");
      frame("19", 1, 3'h7, 1'b0);
      chk_rsp("10~");
      frame("19", 0, 3'h3, 1'b0);
      chk_rsp("11~");
      frame("19", -1, 3'h0, 1'b0);
      chk_rsp("14~");
      frame("113", -1, 3'h0, 1'b0);
      chk_rsp("14~");
      s = "10";
      repeat (138) s = {s, "A"};
      frame(s, -1, 3'h0, 1'b0);
      chk_rsp({"00", s.substr(2, 139), "~"});
      frame({s, "A"}, -1, 3'h0, 1'b0);
      chk_rsp("18~");
      host.send(8'h31, 5'h0);
      host.send(8'h30, 5'h0);
      chk_rsp("18~");
   endtask

   task automatic t_count;
      string s;
      carriage_return_framing = 1'b0;
      frame("10AB", 1, 3'h4, 1'b0);
      chk_rsp("00AB");
      frame("10AB", -1, 3'h0, 1'b1);
      chk_rsp("13");
      frame("10AB", 2, 3'h2, 1'b1);
      chk_rsp("11");
      s = "10";
      repeat (71) s = {s, "B"};
      frame(s, -1, 3'h0, 1'b0);
      chk_rsp({"00", s.substr(2, 72)});
      frame({s, "B"}, -1, 3'h0, 1'b0);
      chk_rsp("18");
      carriage_return_framing = 1'b1;
   endtask

   task automatic tag_run(input logic [11:0] t, input logic [15:0] ec);
      int s0;
      int k;
      s0 = n_start;
      k = 0;
      frame("31", -1, 3'h0, 1'b0);
      while (n_start == s0 && k < 50)
      begin
         @(negedge ref_clk);
         k++;
      end
      chk_val("tag start", 16'h1, 16'(n_start - s0));
      chk_val("tag command", 16'h3331, tag_cmd);
      repeat (3) @(negedge ref_clk);
      tag_res <= {1'b1, t};
      @(negedge ref_clk);
      tag_res <= {1'b0, ~t};
      chk_rsp($sformatf("%c%c~", ec[15:8], ec[7:0]));
   endtask

   task automatic t_tags;
      logic [11:0] tin [17] = '{12'h200, 12'h400, 12'h600, 12'h900, 12'h800, 12'ha01, 12'ha02,
         12'ha03, 12'ha0f, 12'ha20, 12'ha10, 12'ha11, 12'ha12, 12'ha13, 12'ha14, 12'hc00, 12'h000};
      logic [15:0] tex [17] = '{EC_COMM, EC_WRITE, EC_NOTAG, EC_NOTAG, EC_ADDR, EC_CMD, EC_CMD,
         EC_CMD, EC_CMD, EC_CMD, EC_ADDR, EC_OK, EC_WRITE, EC_WRITE, EC_WRITE, EC_FORMAT, EC_OK};
      for (int i = 0; i < 17; i++)
         tag_run(tin[i], tex[i]);
      chk_val("sleep after reply", 16'h1, {15'h0, sleep});
   endtask

   task automatic t_continuous;
      int a0;
      int b0;
      comm_mode = 4'h8;
      tag_run(12'h000, EC_OK);
      chk_val("oscillation kept", 16'h1, {15'h0, osc_en});
      comm_mode = MODE_CONT;
      tag_run(12'h000, EC_OK);
      a0 = n_next;
      frame("11", -1, 3'h0, 1'b0);
      chk_rsp("");
      chk_val("next read", 16'h1, 16'(n_next - a0));
      b0 = n_abort;
      frame("13", -1, 3'h0, 1'b0);
      chk_rsp("00~");
      chk_val("abort pulse", 16'h1, 16'(n_abort - b0));
      chk_val("oscillation", 16'h0, {15'h0, osc_en});
      chk_val("sleep", 16'h1, {15'h0, sleep});
      a0 = n_next;
      frame("11", -1, 3'h0, 1'b0);
      chk_rsp("");
      chk_val("idle acknowledge", 16'h0, 16'(n_next - a0));
   endtask

   initial
   begin
      #2_000_000;
      err_count++;
      conclude;
   end

   initial
   begin
      err_count = 0;
      n_checks = 0;
      n_start = 0;
      n_next = 0;
      n_abort = 0;
      srst = 1'b1;
      carriage_return_framing = 1'b1;
      comm_mode = 4'h0;
      tag_res = '0;
      slow = 1'b0;
      repeat (5) @(negedge ref_clk);
      chk_val("reset tx valid", 16'h0, {15'h0, tx_valid});
      chk_val("reset sleep", 16'h1, {15'h0, sleep});
      chk_val("reset oscillation", 16'h0, {15'h0, osc_en});
      chk_val("reset tag command", 16'h0, tag_cmd);
      srst = 1'b0;
      @(negedge ref_clk);
      t_link;
      t_count;
      t_tags;
      t_continuous;
      conclude;
   end
endmodule
